// >>> common/sgs_pkg.sv
// Constants and types shared by the setpoint group selector
package sgs_pkg;

    // Register byte addresses
    localparam logic [7:0] SGS_GROUP_CFG_ADDR    = 8'h00;
    localparam logic [7:0] SGS_ACTIVE_GROUP_ADDR = 8'h04;
    localparam logic [7:0] SGS_DISPLAY_ADDR      = 8'h08;
    localparam logic [7:0] SGS_RAMP_UNIT_ADDR    = 8'h0C;
    localparam logic [7:0] SGS_CONTACT_CFG_ADDR  = 8'h10;
    localparam logic [7:0] SGS_PID_P_ADDR        = 8'h14;
    localparam logic [7:0] SGS_PID_I_ADDR        = 8'h18;
    localparam logic [7:0] SGS_PID_D_ADDR        = 8'h1C;
    localparam logic [7:0] SGS_TUNE_CTRL_ADDR    = 8'h20;
    localparam logic [7:0] SGS_SP_LOW_ADDR       = 8'h24;
    localparam logic [7:0] SGS_SP_HIGH_ADDR      = 8'h28;
    localparam logic [7:0] SGS_PV_DP_ADDR        = 8'h2C;
    localparam logic [7:0] SGS_LSP_BASE_ADDR     = 8'h30;
    localparam logic [7:0] SGS_OP_SP_ADDR        = 8'h40;
    localparam logic [7:0] SGS_STATUS_ADDR       = 8'h44;

    // Field positions
    localparam int SGS_DISP_SP_BIT      = 1;
    localparam int SGS_DISP_GROUP_BIT   = 2;
    localparam int SGS_CONTACT_FIELD_W  = 8;
    localparam int SGS_TUNE_METHOD_BIT  = 0;

    // Values after reset
    localparam logic [2:0]  SGS_GROUP_COUNT_RST = 3'h1;
    localparam logic [3:0]  SGS_ACTIVE_RST      = 4'h1;
    localparam logic [7:0]  SGS_DISPLAY_RST     = 8'h00;
    localparam logic [1:0]  SGS_RAMP_UNIT_RST   = 2'h0;
    localparam logic [15:0] SGS_PID_P_RST       = 16'h0032; // 5.0 % in tenths
    localparam logic [15:0] SGS_PID_I_RST       = 16'h0078; // 120 s
    localparam logic [15:0] SGS_PID_D_RST       = 16'h001E; // 30 s
    localparam logic [15:0] SGS_LSP_RST         = 16'h0000;
    localparam logic [15:0] SGS_SP_LOW_RST      = 16'h8000;
    localparam logic [15:0] SGS_SP_HIGH_RST     = 16'h7FFF;

    // Limits and codes
    localparam logic [2:0] SGS_GROUP_MAX       = 3'h4;
    localparam logic [1:0] SGS_RAMP_UNIT_MAX   = 2'h2;
    localparam logic [4:0] SGS_CONTACT_CODE_MAX = 5'h14;
    localparam logic [4:0] SGS_CODE_WEIGHT1    = 5'h01;
    localparam logic [4:0] SGS_CODE_WEIGHT2    = 5'h02;
    localparam logic [4:0] SGS_CODE_WEIGHT4    = 5'h03;
    localparam logic [2:0] SGS_HUNT_LIMIT      = 3'h4;

    typedef struct packed {
        logic [15:0] p;
        logic [15:0] i;
        logic [15:0] d;
    } sgs_pid_t;

    typedef struct packed {
        logic run;
        logic auto_mode;
        logic power_fail;
        logic pv_alarm;
    } sgs_loop_t;

endpackage

// >>> rtl/sgs_setpoint_group_selector.sv
// Setpoint group selection, self-tuning gate and display control
//
// The placing of the registers and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module sgs_setpoint_group_selector (
    // Clock and reset
    input  wire logic               MCLK,
    input  wire logic               NRST,
    // AXI4-Lite write address and data
    input  wire logic [7:0]         S_AXI_AWADDR,
    input  wire logic               S_AXI_AWVALID,
    output logic                    S_AXI_AWREADY,
    input  wire logic [31:0]        S_AXI_WDATA,
    input  wire logic [3:0]         S_AXI_WSTRB,
    input  wire logic               S_AXI_WVALID,
    output logic                    S_AXI_WREADY,
    // AXI4-Lite write response
    output logic [1:0]              S_AXI_BRESP,
    output logic                    S_AXI_BVALID,
    input  wire logic               S_AXI_BREADY,
    // AXI4-Lite read
    input  wire logic [7:0]         S_AXI_ARADDR,
    input  wire logic               S_AXI_ARVALID,
    output logic                    S_AXI_ARREADY,
    output logic [31:0]             S_AXI_RDATA,
    output logic [1:0]              S_AXI_RRESP,
    output logic                    S_AXI_RVALID,
    input  wire logic               S_AXI_RREADY,
    // Contacts and control loop
    input  wire logic [2:0]         CONTACT_IN,
    input  wire sgs_pkg::sgs_loop_t LOOP_STATE,
    input  wire logic               TUNE_TRIGGER,
    input  wire logic               TUNE_DONE,
    input  wire sgs_pkg::sgs_pid_t  TUNE_RESULT,
    input  wire logic               RAMP_ACTIVE,
    input  wire logic [15:0]        RAMP_SP,
    input  wire logic               SP_EDITING,
    // Setpoint and display outputs
    output logic [3:0]              ACTIVE_GROUP,
    output logic [15:0]             ACTIVE_SP,
    output logic [15:0]             DISPLAY_SP,
    output logic                    SHOW_SP,
    output logic                    SHOW_GROUP,
    output logic                    GROUP_EDITABLE,
    output logic [2:0]              RAMP_UNIT_SEL,
    output logic [2:0]              RAMP_STEP_DP,
    // Tuning outputs
    output sgs_pkg::sgs_pid_t       PID_CONST,
    output logic                    TUNING,
    output logic                    HUNTING
);
    import sgs_pkg::*;

    typedef struct packed {
        logic                  aw_full;
        logic [7:0]            aw_addr;
        logic                  w_full;
        logic [31:0]           w_data;
        logic [3:0]            w_strb;
        logic                  bvalid;
        logic [1:0]            bresp;
        logic                  rvalid;
        logic [31:0]           rdata;
        logic [1:0]            rresp;
        logic [2:0]            group_count;
        logic [3:0]            active_group;
        logic [7:0]            display_setup_word;
        logic [1:0]            ramp_rate_unit;
        logic [1:0]            pv_dp;
        logic [2:0][4:0]       contact_code;
        logic [2:0]            contact_q;
        sgs_pid_t              pid;
        logic                  method_st;
        logic [15:0]           sp_low;
        logic [15:0]           sp_high;
        logic [3:0][15:0]      local_setpoint;
        logic                  tune_run;
        logic                  hunting;
        logic [2:0]            hunt_cnt;
        logic                  alarm_q;
        logic [15:0]           active_sp;
        logic [15:0]           display_sp;
    } sgs_state_t;

    sgs_state_t s;
    sgs_state_t next_s;

    logic [3:0]  weight_sum;
    logic        contact_sel;
    logic        show_group;
    logic        group_editable;
    logic        start_ok;
    logic        keep_run;
    logic [1:0]  sp_idx;
    logic [31:0] wval;
    logic [3:0]  wgroup;
    logic [1:0]  lsp_sel;

    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  strb);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [15:0] clamp(input logic [15:0] v,
                                          input logic [15:0] lo,
                                          input logic [15:0] hi);
        if ($signed(v) < $signed(lo)) begin
            return lo;
        end
        if ($signed(v) > $signed(hi)) begin
            return hi;
        end
        return v;
    endfunction

    function automatic logic [31:0] read_reg(input sgs_state_t st,
                                             input logic [7:0]  a);
        logic [1:0] n;
        read_reg = 32'h0;
        n = a[3:2];
        case (a)
            SGS_GROUP_CFG_ADDR:    read_reg[2:0] = st.group_count;
            SGS_ACTIVE_GROUP_ADDR: read_reg[3:0] = st.active_group;
            SGS_DISPLAY_ADDR:      read_reg[7:0] = st.display_setup_word;
            SGS_RAMP_UNIT_ADDR:    read_reg[1:0] = st.ramp_rate_unit;
            SGS_CONTACT_CFG_ADDR: begin
                for (int c = 0; c < 3; c++) begin
                    read_reg[c*SGS_CONTACT_FIELD_W +: 5] = st.contact_code[c];
                end
            end
            SGS_PID_P_ADDR:        read_reg[15:0] = st.pid.p;
            SGS_PID_I_ADDR:        read_reg[15:0] = st.pid.i;
            SGS_PID_D_ADDR:        read_reg[15:0] = st.pid.d;
            SGS_TUNE_CTRL_ADDR:    read_reg[SGS_TUNE_METHOD_BIT] = st.method_st;
            SGS_SP_LOW_ADDR:       read_reg[15:0] = st.sp_low;
            SGS_SP_HIGH_ADDR:      read_reg[15:0] = st.sp_high;
            SGS_PV_DP_ADDR:        read_reg[1:0] = st.pv_dp;
            default:               read_reg = 32'h0;
        endcase
        if (a[7:4] == SGS_LSP_BASE_ADDR[7:4]
            && {1'b0, n} < st.group_count) begin // Hidden groups read 0
            read_reg[15:0] = st.local_setpoint[n];
        end
        if (a == SGS_OP_SP_ADDR && st.display_setup_word[SGS_DISP_SP_BIT]) begin
            read_reg[15:0] = st.active_sp;
        end
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        return (a[1:0] == 2'h0) && (a <= SGS_STATUS_ADDR);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Contact weights and display decode
    always_comb begin
        weight_sum = 4'h0;
        contact_sel = 1'b0;
        for (int c = 0; c < 3; c++) begin
            case (s.contact_code[c])
                SGS_CODE_WEIGHT1: begin
                    contact_sel = 1'b1;
                    weight_sum = weight_sum + {3'h0, s.contact_q[c]};
                end
                SGS_CODE_WEIGHT2: begin
                    contact_sel = 1'b1;
                    weight_sum = weight_sum + {2'h0, s.contact_q[c], 1'b0};
                end
                SGS_CODE_WEIGHT4: begin
                    contact_sel = 1'b1;
                    weight_sum = weight_sum + {1'b0, s.contact_q[c], 2'h0};
                end
                default: weight_sum = weight_sum;
            endcase
        end
        show_group = (s.group_count >= 3'h2)
                   && s.display_setup_word[SGS_DISP_GROUP_BIT];
        group_editable = show_group && !contact_sel;
        // Both limits are gates on the stored constants, not on results
        start_ok = s.method_st && LOOP_STATE.run && LOOP_STATE.auto_mode
                && (s.pid.i != 16'h0)
                && (s.pid.d != 16'h0)
                && !LOOP_STATE.power_fail;
        keep_run = s.method_st && LOOP_STATE.run && LOOP_STATE.auto_mode
                && !LOOP_STATE.power_fail;
        // Groups beyond four fold back onto the four stored values
        sp_idx = 2'(s.active_group - 4'h1);
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        next_s = s;
        wval = 32'h0;
        wgroup = 4'h0;
        lsp_sel = 2'h0;
        next_s.contact_q = CONTACT_IN;
        next_s.alarm_q = LOOP_STATE.pv_alarm;
        if (s.group_count != 3'h1 && contact_sel) begin
            next_s.active_group = weight_sum + 4'h1;
        end

        // Bus channels
        if (S_AXI_AWVALID && !s.aw_full) begin
            next_s.aw_full = 1'b1;
            next_s.aw_addr = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && !s.w_full) begin
            next_s.w_full = 1'b1;
            next_s.w_data = S_AXI_WDATA;
            next_s.w_strb = S_AXI_WSTRB;
        end
        if (s.bvalid && S_AXI_BREADY) begin
            next_s.bvalid = 1'b0;
        end
        if (s.rvalid && S_AXI_RREADY) begin
            next_s.rvalid = 1'b0;
        end
        if (S_AXI_ARVALID && !s.rvalid) begin
            next_s.rvalid = 1'b1;
            next_s.rdata = read_reg(s, S_AXI_ARADDR);
            next_s.rresp = mapped(S_AXI_ARADDR) ? 2'b00 : 2'b10;
        end

        // Register writes
        if (s.aw_full && s.w_full && !s.bvalid) begin
            next_s.aw_full = 1'b0;
            next_s.w_full = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = mapped(s.aw_addr) ? 2'b00 : 2'b10;
            wval = merge(read_reg(s, s.aw_addr), s.w_data, s.w_strb);
            wgroup = wval[3:0];
            lsp_sel = s.aw_addr[3:2];
            case (s.aw_addr)
                SGS_GROUP_CFG_ADDR: begin
                    if (wval[2:0] >= 3'h1 && wval[2:0] <= SGS_GROUP_MAX) begin
                        next_s.group_count = wval[2:0];
                    end
                end
                SGS_ACTIVE_GROUP_ADDR: begin
                    if (group_editable && wgroup >= 4'h1
                        && wgroup <= {1'b0, s.group_count}) begin
                        next_s.active_group = wgroup;
                    end
                end
                SGS_DISPLAY_ADDR:   next_s.display_setup_word = wval[7:0];
                SGS_RAMP_UNIT_ADDR: begin
                    if (wval[1:0] <= SGS_RAMP_UNIT_MAX) begin
                        next_s.ramp_rate_unit = wval[1:0];
                    end
                end
                SGS_CONTACT_CFG_ADDR: begin
                    for (int c = 0; c < 3; c++) begin
                        if (wval[c*SGS_CONTACT_FIELD_W +: 5]
                            <= SGS_CONTACT_CODE_MAX) begin
                            next_s.contact_code[c] =
                                wval[c*SGS_CONTACT_FIELD_W +: 5];
                        end
                    end
                end
                SGS_PID_P_ADDR:     next_s.pid.p = wval[15:0];
                SGS_PID_I_ADDR:     next_s.pid.i = wval[15:0];
                SGS_PID_D_ADDR:     next_s.pid.d = wval[15:0];
                SGS_TUNE_CTRL_ADDR: next_s.method_st = wval[SGS_TUNE_METHOD_BIT];
                SGS_SP_LOW_ADDR:    next_s.sp_low = wval[15:0];
                SGS_SP_HIGH_ADDR:   next_s.sp_high = wval[15:0];
                SGS_PV_DP_ADDR:     next_s.pv_dp = wval[1:0];
                SGS_OP_SP_ADDR: begin
                    if (s.display_setup_word[SGS_DISP_SP_BIT]) begin
                        next_s.local_setpoint[sp_idx] =
                            clamp(wval[15:0], s.sp_low, s.sp_high);
                    end
                end
                default: begin
                    if (s.aw_addr[7:4] == SGS_LSP_BASE_ADDR[7:4]
                        && {1'b0, lsp_sel} < s.group_count) begin
                        next_s.local_setpoint[lsp_sel] =
                            clamp(wval[15:0], s.sp_low, s.sp_high);
                    end
                end
            endcase
        end

        // Self-tuning run
        if (!s.tune_run) begin
            if (TUNE_TRIGGER && start_ok) begin
                next_s.tune_run = 1'b1;
                next_s.hunting = 1'b0;
                next_s.hunt_cnt = 3'h0;
            end
        end else if (!keep_run) begin
            // Abort drops the run; stored constants are untouched
            next_s.tune_run = 1'b0;
        end else begin
            if (LOOP_STATE.pv_alarm != s.alarm_q
                && s.hunt_cnt != SGS_HUNT_LIMIT) begin
                next_s.hunt_cnt = s.hunt_cnt + 3'h1;
            end
            if (next_s.hunt_cnt == SGS_HUNT_LIMIT) begin
                next_s.hunting = 1'b1;
            end
            if (TUNE_DONE) begin
                next_s.pid = TUNE_RESULT;
                next_s.tune_run = 1'b0;
            end
        end

        next_s.active_sp = s.local_setpoint[sp_idx];
        // Operator edits win so the target is visible while being changed
        next_s.display_sp = (RAMP_ACTIVE && !SP_EDITING) ? RAMP_SP
                          : s.local_setpoint[sp_idx];
    end

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            s <= '0;
            s.group_count <= SGS_GROUP_COUNT_RST;
            s.active_group <= SGS_ACTIVE_RST;
            s.display_setup_word <= SGS_DISPLAY_RST;
            s.ramp_rate_unit <= SGS_RAMP_UNIT_RST;
            s.pid <= '{p: SGS_PID_P_RST, i: SGS_PID_I_RST,
                       d: SGS_PID_D_RST};
            s.sp_low <= SGS_SP_LOW_RST;
            s.sp_high <= SGS_SP_HIGH_RST;
            s.local_setpoint <= {4{SGS_LSP_RST}};
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign S_AXI_AWREADY = !s.aw_full;
    assign S_AXI_WREADY = !s.w_full;
    assign S_AXI_BVALID = s.bvalid;
    assign S_AXI_BRESP = s.bresp;
    assign S_AXI_ARREADY = !s.rvalid;
    assign S_AXI_RVALID = s.rvalid;
    assign S_AXI_RDATA = s.rdata;
    assign S_AXI_RRESP = s.rresp;
    assign ACTIVE_GROUP = s.active_group;
    assign ACTIVE_SP = s.active_sp;
    assign DISPLAY_SP = s.display_sp;
    assign SHOW_SP = s.display_setup_word[SGS_DISP_SP_BIT];
    assign SHOW_GROUP = show_group;
    assign GROUP_EDITABLE = group_editable;
    assign RAMP_UNIT_SEL = 3'h1 << s.ramp_rate_unit;
    assign RAMP_STEP_DP = {1'b0, s.pv_dp} + 3'h1;
    assign PID_CONST = s.pid;
    assign TUNING = s.tune_run;
    assign HUNTING = s.hunting;

endmodule
`default_nettype wire

// >>> testbench/sgs_checker_assertions.sv
// Port-level assertions for the setpoint group selector
`timescale 1ns/100ps
`default_nettype none
module sgs_checker (
    // Clock and reset
    input wire logic               MCLK,
    input wire logic               NRST,
    // Loop and tuning
    input wire sgs_pkg::sgs_loop_t LOOP_STATE,
    input wire logic               TUNE_DONE,
    input wire sgs_pkg::sgs_pid_t  TUNE_RESULT,
    input wire sgs_pkg::sgs_pid_t  PID_CONST,
    input wire logic               TUNING,
    // Ramp and display
    input wire logic               RAMP_ACTIVE,
    input wire logic               SP_EDITING,
    input wire logic [15:0]        RAMP_SP,
    input wire logic [15:0]        DISPLAY_SP,
    input wire logic               SHOW_GROUP,
    input wire logic               GROUP_EDITABLE,
    input wire logic [2:0]         RAMP_UNIT_SEL,
    input wire logic [3:0]         ACTIVE_GROUP
);
    import sgs_pkg::*;
    default clocking @(posedge MCLK); endclocking
    default disable iff (!NRST);
    a_tune_zero_int: assert property (
        $rose(TUNING) |-> $past(PID_CONST.i) != 16'h0000)
        else $error("tuning began with zero integral time");
    a_tune_zero_der: assert property (
        $rose(TUNING) |-> $past(PID_CONST.d) != 16'h0000)
        else $error("tuning began with zero derivative time");
    a_tune_modes: assert property (
        $rose(TUNING) |-> $past(LOOP_STATE.run && LOOP_STATE.auto_mode))
        else $error("tuning began outside run and automatic");
    a_power_loss_keep: assert property (
        TUNING && LOOP_STATE.power_fail && !TUNE_DONE
        |=> !TUNING && PID_CONST == $past(PID_CONST))
        else $error("power loss altered constants or kept tuning");
    a_result_load: assert property (
        TUNING && TUNE_DONE && LOOP_STATE.run && LOOP_STATE.auto_mode
        && !LOOP_STATE.power_fail
        |=> !TUNING && PID_CONST == $past(TUNE_RESULT))
        else $error("tuning result not taken");
    a_ramp_display: assert property (
        RAMP_ACTIVE && !SP_EDITING |=> DISPLAY_SP == $past(RAMP_SP))
        else $error("ramping setpoint not displayed");
    a_edit_needs_show: assert property (
        GROUP_EDITABLE |-> SHOW_GROUP)
        else $error("group editable while hidden");
    a_unit_onehot: assert property ($onehot(RAMP_UNIT_SEL))
        else $error("ramp unit select not one-hot");
    a_group_range: assert property (
        ACTIVE_GROUP inside {[4'h1:4'h8]})
        else $error("active group out of range");
endmodule
bind sgs_setpoint_group_selector sgs_checker i_sgs_checker (
    .MCLK, .NRST, .LOOP_STATE, .TUNE_DONE, .TUNE_RESULT, .PID_CONST,
    .TUNING, .RAMP_ACTIVE, .SP_EDITING, .RAMP_SP, .DISPLAY_SP,
    .SHOW_GROUP, .GROUP_EDITABLE, .RAMP_UNIT_SEL, .ACTIVE_GROUP);
`default_nettype wire

// >>> testbench/sgs_contact_model.sv
// Behavioural model of the contact inputs and the front-panel operator
`timescale 1ns/100ps
`default_nettype none
module sgs_contact_model (
    // Clock
    input  wire logic       clk,
    // Levels asked for by the bench
    input  wire logic [2:0] want,
    input  wire logic       edit_want,
    // Levels seen by the block
    output var logic [2:0]  contact = 3'h0,
    output var logic        editing = 1'b0
);
    // Contacts settle one clock late, as a debounced input would
    always @(posedge clk) begin
        contact <= want;
        editing <= edit_want;
    end
endmodule
`default_nettype wire

// >>> testbench/tb.sv
// Self-checking bench for the setpoint group selector
`timescale 1ns/100ps
`default_nettype none
module tb;
    import sgs_pkg::*;
    logic        MCLK, NRST, awv, wv, br, arv, rr, trig, done, ract, ed_w;
    logic        awr, wrd, bv, arr, rv, shs, shg, ged, tun, hun, edg;
    logic [7:0]  aw, ar;
    logic [31:0] wd, rdata;
    logic [1:0]  bresp, rresp;
    logic [2:0]  c_w, cin, unit, step;
    logic [3:0]  grp;
    logic [15:0] rsp_sp, dsp, asp;
    sgs_loop_t   lp;
    sgs_pid_t    res, pid;
    int          error_cnt, num_checks;
    sgs_setpoint_group_selector i_sgs_setpoint_group_selector (
        .MCLK(MCLK), .NRST(NRST), .S_AXI_AWADDR(aw), .S_AXI_AWVALID(awv),
        .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF),
        .S_AXI_WVALID(wv), .S_AXI_WREADY(wrd), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bv), .S_AXI_BREADY(br), .S_AXI_ARADDR(ar),
        .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rr),
        .CONTACT_IN(cin), .LOOP_STATE(lp), .TUNE_TRIGGER(trig),
        .TUNE_DONE(done), .TUNE_RESULT(res), .RAMP_ACTIVE(ract),
        .RAMP_SP(rsp_sp), .SP_EDITING(edg), .ACTIVE_GROUP(grp),
        .ACTIVE_SP(asp), .DISPLAY_SP(dsp), .SHOW_SP(shs), .SHOW_GROUP(shg),
        .GROUP_EDITABLE(ged), .RAMP_UNIT_SEL(unit), .RAMP_STEP_DP(step),
        .PID_CONST(pid), .TUNING(tun), .HUNTING(hun));
    sgs_contact_model i_sgs_contact_model (.clk(MCLK), .want(c_w),
        .edit_want(ed_w), .contact(cin), .editing(edg));
    initial begin
        MCLK = 1'b0;
        forever #50 MCLK = ~MCLK;
    end
    ////////////////////////////////////////////////////////////////////////
    task chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task tally_and_finish;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Sample a little after the edge so its updates have landed
    task w(input int n);
        repeat (n) @(posedge MCLK);
        #1;
    endtask
    // Ready is sampled at the negedge; it cannot move before the next edge
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        logic ra, rw, rb;
        @(posedge MCLK);
        {aw, wd, awv, wv, br} <= {a, d, 3'h7};
        for (int n = 0; n < 20; n++) begin
            @(negedge MCLK);
            {ra, rw, rb} = {awr, wrd, bv};
            if (rb) chk(32'(bresp), 32'(e));
            @(posedge MCLK);
            if (ra) awv <= 1'b0;
            if (rw) wv <= 1'b0;
            if (rb) break;
        end
        br <= 1'b0;
        if (!rb) begin
            error_cnt++;
            tally_and_finish;
        end
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        logic ra, rb;
        @(posedge MCLK);
        {ar, arv, rr} <= {a, 2'h3};
        for (int n = 0; n < 20; n++) begin
            @(negedge MCLK);
            {ra, rb} = {arr, rv};
            if (rb) chk(rdata, e);
            if (rb) chk(32'(rresp), a > SGS_STATUS_ADDR ? 32'h2 : 32'h0);
            @(posedge MCLK);
            if (ra) arv <= 1'b0;
            if (rb) break;
        end
        rr <= 1'b0;
        if (!rb) begin
            error_cnt++;
            tally_and_finish;
        end
    endtask
    task trg(input sgs_loop_t l);
        @(posedge MCLK);
        {lp, trig} <= {l, 1'b1};
        @(posedge MCLK);
        trig <= 1'b0;
        w(2);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task t_reset;
        rd(SGS_PID_P_ADDR, 32'h32);
        rd(SGS_PID_I_ADDR, 32'h78);
        rd(SGS_PID_D_ADDR, 32'h1E);
        rd(SGS_GROUP_CFG_ADDR, 32'h1);
        rd(SGS_LSP_BASE_ADDR, 32'h0);
        rd(SGS_RAMP_UNIT_ADDR, 32'h0);
        wr(8'h48, 32'h1, 2'h2);
        rd(8'h48, 32'h0);
        chk(32'(grp), 32'h1);
    endtask
    task t_contacts;
        wr(SGS_CONTACT_CFG_ADDR, 32'h00030201, 2'h0);
        c_w <= 3'h7;
        w(4);
        chk(32'(grp), 32'h1);
        wr(SGS_GROUP_CFG_ADDR, 32'h4, 2'h0);
        for (int v = 0; v < 8; v++) begin
            @(posedge MCLK);
            c_w <= 3'(v);
            w(4);
            chk(32'(grp), 32'(v + 1));
        end
        @(posedge MCLK);
        c_w <= 3'h0;
        wr(SGS_CONTACT_CFG_ADDR, 32'h0, 2'h0);
    endtask
    task t_setpoints;
        wr(SGS_SP_HIGH_ADDR, 32'h200, 2'h0);
        wr(SGS_LSP_BASE_ADDR, 32'h300, 2'h0);
        rd(SGS_LSP_BASE_ADDR, 32'h200);
        wr(SGS_GROUP_CFG_ADDR, 32'h5, 2'h0);
        rd(SGS_GROUP_CFG_ADDR, 32'h4);
        wr(SGS_GROUP_CFG_ADDR, 32'h2, 2'h0);
        wr(SGS_LSP_BASE_ADDR + 8'h04, 32'h123, 2'h0);
        rd(SGS_LSP_BASE_ADDR + 8'h04, 32'h123);
        wr(SGS_LSP_BASE_ADDR + 8'h08, 32'h5, 2'h0);
        rd(SGS_LSP_BASE_ADDR + 8'h08, 32'h0);
        wr(SGS_GROUP_CFG_ADDR, 32'h3, 2'h0);
        rd(SGS_LSP_BASE_ADDR + 8'h08, 32'h0);
        wr(SGS_GROUP_CFG_ADDR, 32'h2, 2'h0);
    endtask
    task t_display;
        chk(32'(shg), 32'h0);
        wr(SGS_DISPLAY_ADDR, 32'h6, 2'h0);
        w(1);
        chk(32'({shs, shg, ged}), 32'h7);
        wr(SGS_ACTIVE_GROUP_ADDR, 32'h2, 2'h0);
        w(3);
        chk(32'(grp), 32'h2);
        chk(32'(asp), 32'h123);
        wr(SGS_ACTIVE_GROUP_ADDR, 32'h3, 2'h0);
        rd(SGS_ACTIVE_GROUP_ADDR, 32'h2);
        rd(SGS_OP_SP_ADDR, 32'h123);
        wr(SGS_OP_SP_ADDR, 32'h150, 2'h0);
        rd(SGS_LSP_BASE_ADDR + 8'h04, 32'h150);
        wr(SGS_DISPLAY_ADDR, 32'h0, 2'h0);
        rd(SGS_OP_SP_ADDR, 32'h0);
        wr(SGS_OP_SP_ADDR, 32'h1, 2'h0);
        rd(SGS_LSP_BASE_ADDR + 8'h04, 32'h150);
    endtask
    task t_ramp;
        for (int u = 0; u < 4; u++) begin
            wr(SGS_RAMP_UNIT_ADDR, 32'(u), 2'h0);
            w(1);
            chk(32'(unit), 32'(u < 3 ? 1 << u : 4));
        end
        wr(SGS_PV_DP_ADDR, 32'h1, 2'h0);
        w(1);
        chk(32'(step), 32'h2);
        @(posedge MCLK);
        {ract, rsp_sp} <= {1'b1, 16'h0555};
        w(3);
        chk(32'(dsp), 32'h555);
        @(posedge MCLK);
        ed_w <= 1'b1;
        w(4);
        chk(32'(dsp), 32'h150);
        @(posedge MCLK);
        {ract, ed_w} <= 2'h0;
    endtask
    task t_tune;
        wr(SGS_TUNE_CTRL_ADDR, 32'h1, 2'h0);
        wr(SGS_PID_I_ADDR, 32'h0, 2'h0);
        trg(4'hC);
        chk(32'(tun), 32'h0);
        wr(SGS_PID_I_ADDR, 32'h78, 2'h0);
        wr(SGS_PID_D_ADDR, 32'h0, 2'h0);
        trg(4'hC);
        chk(32'(tun), 32'h0);
        wr(SGS_PID_D_ADDR, 32'h1E, 2'h0);
        trg(4'h4);
        chk(32'(tun), 32'h0);
        trg(4'hC);
        chk(32'(tun), 32'h1);
        @(posedge MCLK);
        lp <= 4'hE;
        w(2);
        chk(32'({tun, pid.i}), 32'h78);
        trg(4'hC);
        for (int k = 0; k < 4; k++) begin
            @(posedge MCLK);
            lp.pv_alarm <= ~lp.pv_alarm;
        end
        w(2);
        chk(32'(hun), 32'h1);
        @(posedge MCLK);
        {res, done} <= {48'h0011_0022_0033, 1'b1};
        @(posedge MCLK);
        done <= 1'b0;
        w(1);
        chk(32'({tun, pid.p}), 32'h11);
    endtask
    // A second reset after the tuning run has ended must bring the defaults back
    task t_rst2;
        @(posedge MCLK);
        NRST <= 1'b0;
        @(posedge MCLK);
        NRST <= 1'b1;
        rd(SGS_PID_P_ADDR, 32'h32);
        chk(32'(grp), 32'h1);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {NRST, awv, wv, br, arv, rr, trig, done, ract, ed_w} = 10'h0;
        {aw, ar, wd, c_w, rsp_sp, lp, res} = '0;
        repeat (2) @(posedge MCLK);
        NRST <= 1'b1;
        t_reset;
        t_contacts;
        t_setpoints;
        t_display;
        t_ramp;
        t_tune;
        t_rst2;
        tally_and_finish;
    end
endmodule
`default_nettype wire
